// file: logic/cfp_chan_guard.sv
// One channel's fault detection: comparator synchronisers, overcurrent
// filter and the routing of overcurrent events to flag types.
// Assumes the comparators are asynchronous to aclk.
`timescale 1ns/1ps
module cfp_chan_guard
  import cfp_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire cfp_chan_sense_t sense,
  input  wire logic            high_side,
  input  wire logic            stage_on,
  output logic                 ovc_evt,
  output logic                 open_load_bypass_flag_evt,
  output logic                 quick_off,
  output logic                 overtemp
);
  import cfp_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  cfp_chan_sense_t meta_q;
  cfp_chan_sense_t sync_q;
  logic [5:0]      filt_q;
  logic            low_any;
  logic            filt_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= sense;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent filter
  // ----------------------------------------------------------------
  // The filter restarts whenever the current drops below the low limit
  assign low_any   = sync_q.oc_low_hs | sync_q.oc_low_ls;
  assign filt_done = (filt_q == OC_FILTER_CYCLES);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q <= '0;
    end else if (!low_any || !stage_on) begin
      filt_q <= '0;
    end else if (!filt_done) begin
      filt_q <= filt_q + 6'd1;
    end
  end

  // Quick shutoff bypasses the filter entirely
  assign quick_off = sync_q.oc_high_hs | sync_q.oc_high_ls;

  // ----------------------------------------------------------------
  // Fault assignment
  // ----------------------------------------------------------------
  logic hs_fet;
  logic ls_fet;
  assign hs_fet = sync_q.oc_high_hs | (filt_done & sync_q.oc_low_hs);
  assign ls_fet = sync_q.oc_high_ls | (filt_done & sync_q.oc_low_ls);

  // Own-side FET gives overcurrent, opposite FET means a bypass
  assign ovc_evt  = stage_on & (high_side ? hs_fet : ls_fet);
  assign open_load_bypass_flag_evt = stage_on & ((high_side ? ls_fet : hs_fet)
                                | sync_q.open_load_on);
  assign overtemp = sync_q.overtemp;

endmodule

// file: logic/cfp_top.sv
// Two-channel fault protection with an AXI4-Lite register slave.
// Assumes comparator inputs are asynchronous and software drives the bus.
//
// How it works
// - Overload turns stage off, clears setpoint and enable, latches fault flag.
// - Reading the diagnosis register clears latched overcurrent flags.
// - Current above quick limit disables the stage at once.
// - Current between limits faults only after the filter time.
// - Filter time lies between 20 and 40 system clocks.
// - Overcurrent maps to overcurrent or bypass flag by side and FET.
// - Overtemperature turns channel off, clears setpoint and enable, latches flag.
// - Hot channel stays off until its indication drops by the hysteresis.
// - After overtemperature, need diag read, enable set and setpoint nonzero.
// - Overtemperature flag clears on diag read once the condition is gone.
// - Overvoltage flag latches; clears on diag read without overvoltage.
// - During overvoltage all channels off, setpoints and enables cleared.
// - After overvoltage, need diag read, enable set and setpoint nonzero.
// - Pump undervoltage and overvoltage flags are independent, any order.
// - PWM period covers 16 to 65520 system clocks.
// - PWM period code steps are 16 system clocks.
// - One setpoint code is 1500/2047 mA.
`timescale 1ns/1ps
module cfp_top
  import cfp_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire cfp_chan_sense_t [1:0] sense,
  input  wire logic                 battery_overvoltage,
  input  wire logic                 pump_undervoltage,
  output cfp_chan_drive_t [1:0]     drive
);
  import cfp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]       sp_q [2];
  logic [11:0]       pwm_q [2];
  logic [1:0]        cfg_q;
  cfp_flags_t [1:0]  flag_q;
  logic              ov_flag_q;
  logic              pump_undervoltage_flag_flag_q;
  logic [1:0]        lock_q;     // Waits for a diagnosis read after an overtemperature or overvoltage shutdown
  logic [1:0]        ov_meta_q;
  logic [1:0]        ov_sync_q;
  logic [1:0]        ovc_evt;
  logic [1:0]        open_load_bypass_flag_evt;
  logic [1:0]        quick_off;
  logic [1:0]        overtemp;
  logic [1:0]        stage_on;
  logic [1:0]        armed;      // Ready to run, before the quick shutoff
  logic [1:0]        fault_kill;
  logic              ov_now;
  logic              pump_undervoltage_flag_now;

  // Bus state
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        rd_fire;
  logic        diag_read;

  assign ov_now   = ov_sync_q[1];
  assign pump_undervoltage_flag_now = ov_sync_q[0];

  // ----------------------------------------------------------------
  // Supply comparator synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_meta_q <= '0;
      ov_sync_q <= '0;
    end else begin
      ov_meta_q <= {battery_overvoltage, pump_undervoltage};
      ov_sync_q <= ov_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Channel detectors
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    cfp_chan_guard u_guard (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sense     (sense[ch]),
      .high_side (cfg_q[ch]),
      .stage_on  (armed[ch]),   // Not stage_on, so a quick shutoff still latches
      .ovc_evt   (ovc_evt[ch]),
      .open_load_bypass_flag_evt  (open_load_bypass_flag_evt[ch]),
      .quick_off (quick_off[ch]),
      .overtemp  (overtemp[ch])
    );

    // Any shutdown source for this channel
    assign fault_kill[ch] = ovc_evt[ch] | open_load_bypass_flag_evt[ch] | overtemp[ch] | ov_now;

    // Stage runs only when enabled, setpoint nonzero and nothing holds it off
    assign armed[ch]    = sp_q[ch][SP_EN_BIT] && (sp_q[ch][SP_CODE_MSB:0] != 11'h000)
                          && !lock_q[ch] && !overtemp[ch] && !ov_now;
    assign stage_on[ch] = armed[ch] && !quick_off[ch];

    assign drive[ch].stage_on   = stage_on[ch];
    assign drive[ch].high_side  = cfg_q[ch];
    // Code counts 1500/2047 mA per step; the analog loop uses it as is
    assign drive[ch].setpoint   = sp_q[ch][SP_CODE_MSB:0];
    assign drive[ch].pwm_cycles = cfp_pwm_cycles(pwm_q[ch]);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q[7:2] <= ADDR_CONFIG[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = d[7:0];
    end
    if (st[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Setpoint and enable, with fault clearing
  // ----------------------------------------------------------------
  // Hardware clear beats a software write in the same cycle: a fault must win
  for (genvar ch = 0; ch < 2; ch++) begin : g_sp
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sp_q[ch] <= SETPOINT_RST;
      end else if (fault_kill[ch]) begin
        sp_q[ch] <= SETPOINT_RST;
      end else if (wr_fire && aw_addr_q == (ch == 0 ? ADDR_SETPOINT0 : ADDR_SETPOINT1)) begin
        sp_q[ch] <= merge16(sp_q[ch], w_data_q, w_strb_q) & 16'h87ff;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pwm_q[ch] <= PWM_RST;
      end else if (wr_fire && aw_addr_q == (ch == 0 ? ADDR_PWM0 : ADDR_PWM1)) begin
        pwm_q[ch] <= 12'(merge16({4'h0, pwm_q[ch]}, w_data_q, w_strb_q));
      end
    end

    // After over-temperature or over-voltage the host must read diagnosis first
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        lock_q[ch] <= 1'b0;
      end else if (overtemp[ch] || ov_now) begin
        lock_q[ch] <= 1'b1;
      end else if (diag_read) begin
        lock_q[ch] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CONFIG_RST;
    end else if (wr_fire && aw_addr_q == ADDR_CONFIG && w_strb_q[0]) begin
      cfg_q <= w_data_q[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  // A new event in the clearing cycle keeps its flag set
  for (genvar ch = 0; ch < 2; ch++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_q[ch] <= '0;
      end else begin
        flag_q[ch].ovc  <= ovc_evt[ch] | (flag_q[ch].ovc & !diag_read);
        flag_q[ch].open_load_bypass_flag <= open_load_bypass_flag_evt[ch] | (flag_q[ch].open_load_bypass_flag & !diag_read);
        flag_q[ch].ot   <= overtemp[ch] | (flag_q[ch].ot & !diag_read);
        flag_q[ch].on   <= stage_on[ch];
      end
    end
  end

  // Two independent latches, so either may rise first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_flag_q   <= 1'b0;
      pump_undervoltage_flag_flag_q <= 1'b0;
    end else begin
      ov_flag_q   <= ov_now | (ov_flag_q & !diag_read);
      pump_undervoltage_flag_flag_q <= pump_undervoltage_flag_now | (pump_undervoltage_flag_flag_q & !diag_read);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign diag_read     = rd_fire && s_axi_araddr == ADDR_DIAG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_SETPOINT0: s_axi_rdata <= {16'h0000, sp_q[0]};
        ADDR_SETPOINT1: s_axi_rdata <= {16'h0000, sp_q[1]};
        ADDR_PWM0:      s_axi_rdata <= {20'h00000, pwm_q[0]};
        ADDR_PWM1:      s_axi_rdata <= {20'h00000, pwm_q[1]};
        ADDR_DIAG:      s_axi_rdata <= {22'h000000, pump_undervoltage_flag_flag_q, ov_flag_q,
                                        flag_q[1], flag_q[0]};
        ADDR_CONFIG:    s_axi_rdata <= {30'h00000000, cfg_q};
        ADDR_STATUS:    s_axi_rdata <= {26'h0000000, overtemp, pump_undervoltage_flag_now, ov_now, lock_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: shared/cfp_pkg.sv
// Package for the channel fault protection block: register map, field layout,
// reset values, timing counts and the carrier structs shared by the design.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package cfp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ            = 40_000_000;
  localparam logic [5:0]  OC_FILTER_CYCLES  = 6'd30;    // Inside the 20..40 window
  localparam logic [15:0] PWM_PERIOD_MIN    = 16'h0010;
  localparam logic [15:0] PWM_PERIOD_MAX    = 16'hffff;
  localparam int          PWM_STEP_SHIFT    = 4;        // 16 cycles per lsb
  localparam logic [10:0] SETPOINT_FULL     = 11'h7ff;  // 2047 codes = 1500 mA
  localparam int          SETPOINT_MA_NUM   = 1500;
  localparam int          SETPOINT_MA_DEN   = 2047;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SETPOINT0  = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT1  = 8'h04;
  localparam logic [7:0] ADDR_PWM0       = 8'h08;
  localparam logic [7:0] ADDR_PWM1       = 8'h0c;
  localparam logic [7:0] ADDR_DIAG       = 8'h10;
  localparam logic [7:0] ADDR_CONFIG     = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SP_EN_BIT     = 15;   // Channel enable in SETPOINT
  localparam int SP_CODE_MSB   = 10;   // Setpoint code 10:0
  localparam int DIAG_CH_W     = 4;    // Per channel: ovc, open_load_bypass_flag, ot, on
  localparam int DIAG_OVC      = 0;
  localparam int DIAG_OPEN_LOAD_BYPASS_FLAG     = 1;
  localparam int DIAG_OT       = 2;
  localparam int DIAG_ON       = 3;
  localparam int DIAG_OV_BIT   = 8;
  localparam int DIAG_PUMP_UNDERVOLTAGE_FLAG_BIT = 9;
  localparam int CFG_HS0_BIT   = 0;    // 1 = high-side, 0 = low-side
  localparam int CFG_HS1_BIT   = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [11:0] PWM_RST      = 12'h001;
  localparam logic [1:0]  CONFIG_RST   = 2'h0;

  // AXI4-Lite response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier structs
  // ----------------------------------------------------------------
  // Raw analog comparator indications of one channel
  typedef struct packed {
    logic oc_low_hs;    // Above low limit, high-side FET
    logic oc_low_ls;    // Above low limit, low-side FET
    logic oc_high_hs;   // Above quick-shutoff limit, high-side FET
    logic oc_high_ls;   // Above quick-shutoff limit, low-side FET
    logic open_load_on; // Open load seen in on state
    logic overtemp;     // High until temperature fell by the hysteresis
  } cfp_chan_sense_t;

  // Per-channel drive towards the power stage
  typedef struct packed {
    logic        stage_on;
    logic        high_side;
    logic [10:0] setpoint;
    logic [15:0] pwm_cycles;
  } cfp_chan_drive_t;

  // Per-channel latched faults and the registered on state
  typedef struct packed {
    logic on;
    logic ot;
    logic open_load_bypass_flag;
    logic ovc;
  } cfp_flags_t;

  // Scale a period code to system clock cycles, clamped to the legal range
  function automatic logic [15:0] cfp_pwm_cycles(input logic [11:0] code);
    logic [15:0] c;
    c = {code, 4'h0};
    if (c < PWM_PERIOD_MIN) begin
      c = PWM_PERIOD_MIN;
    end
    return c;
  endfunction

endpackage

// file: verif/cfp_analog_model.sv
// Behavioural comparators and supply monitor facing cfp_top.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ps
module cfp_analog_model
  import cfp_pkg::*;
(
  input  wire cfp_chan_sense_t [1:0] want,
  input  wire logic                  surge,
  input  wire logic                  uv_first,
  output cfp_chan_sense_t [1:0]      sense,
  output logic                       battery_overvoltage,
  output logic                       pump_undervoltage
);
  initial begin
    sense = '0;
    battery_overvoltage = 1'b0;
    pump_undervoltage = 1'b0;
  end
  // Skewed off the clock grid; overtemp stays high until the bench cools it
  always @(want) sense <= #3 want;
  // A surge may trip either monitor first
  always @(posedge surge) begin
    if (uv_first) begin
      pump_undervoltage = 1'b1;
      #40 battery_overvoltage = 1'b1;
    end else begin
      battery_overvoltage = 1'b1;
      #40 pump_undervoltage = 1'b1;
    end
  end
  always @(negedge surge) begin
    battery_overvoltage = 1'b0;
    pump_undervoltage = 1'b0;
  end
endmodule

// file: verif/cfp_top_asserts.sv
// Checker for cfp_top: bus answers, shutdown timing and drive limits.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module cfp_top_asserts
  import cfp_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire cfp_chan_sense_t [1:0] sense,
  input wire logic                  battery_overvoltage,
  input wire cfp_chan_drive_t [1:0] drive
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------
  // Helper
  // --------
  // Cycles a live stage sits above the low limit; saturates
  logic [7:0] oc_hold_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !drive[0].stage_on || !(sense[0].oc_low_hs || sense[0].oc_low_ls)) begin
      oc_hold_q <= 8'h00;
    end else if (oc_hold_q != 8'hff) begin
      oc_hold_q <= oc_hold_q + 8'h01;
    end
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_quick0;
    (sense[0].oc_high_hs || sense[0].oc_high_ls) [*2];
  endsequence
  sequence s_ov_held;
    battery_overvoltage [*3];
  endsequence
  sequence s_hot1;
    sense[1].overtemp [*3];
  endsequence
  // --------
  // Checks
  // --------
  a_write_answer: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_quick_off: assert property (s_quick0 |=> !drive[0].stage_on)
    else $error("stage kept on above quick limit");
  a_filter_bound: assert property (oc_hold_q <= 8'd44)
    else $error("low limit overload not cut in time");
  a_ov_clear: assert property (s_ov_held |=> !drive[0].stage_on && !drive[1].stage_on
    && drive[0].setpoint == 11'h0 && drive[1].setpoint == 11'h0) else $error("overvoltage kept");
  a_hot_clear: assert property (s_hot1 |=> !drive[1].stage_on
    && drive[1].setpoint == 11'h0) else $error("hot channel kept on");
  a_on_needs_code: assert property (drive[0].stage_on |-> drive[0].setpoint != 11'h0)
    else $error("stage on with zero setpoint");
  a_pwm_grid: assert property (drive[0].pwm_cycles[3:0] == 4'h0
    && drive[0].pwm_cycles >= PWM_PERIOD_MIN) else $error("period off grid");
endmodule
bind cfp_top cfp_top_asserts u_cfp_top_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sense(sense),
  .battery_overvoltage(battery_overvoltage), .drive(drive)
);

// file: verif/cfp_top_bench.sv
// Self-checking bench for cfp_top with an AXI4-Lite master and analog model.
// Assumes cfp_pkg map and a 40 MHz clock.
`timescale 1ns/1ps
module cfp_top_bench;
  import cfp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, surge = 1'b0, uv_first = 1'b0, ov, uv;
  logic [1:0] bresp, rresp, r;
  logic [10:0] code;
  cfp_chan_sense_t [1:0] want = '0, sense;
  cfp_chan_drive_t [1:0] drive;
  int miscompares = 0, checks = 0, cycles = 0, n;
  cfp_top u_cfp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense(sense),
    .battery_overvoltage(ov), .pump_undervoltage(uv), .drive(drive));
  cfp_analog_model u_cfp_analog_model (.want(want), .surge(surge), .uv_first(uv_first),
    .sense(sense), .battery_overvoltage(ov), .pump_undervoltage(uv));
  always #12.5 aclk = ~aclk;
  // Hang guard: whole run needs only several hundred cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (!w_done && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic gap(input int k);
    repeat (k) @(posedge aclk);
  endtask
  function automatic logic [15:0] exp_pwm(input logic [11:0] c);
    return ({4'h0, c} < 16'h0001) ? 16'h0010 : {c, 4'h0};
  endfunction
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h42b7));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_SETPOINT0); chk(d, 32'h0);
    rd(ADDR_PWM0); chk(d, 32'h1);
    rd(ADDR_CONFIG); chk(d, 32'h0);
    rd(8'h1c); chk(r, RESP_SLVERR); chk(d, 32'h0);
    wr(8'h20, 32'h1); chk(r, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 32'hfff : $urandom_range(1, 4095);
      wr(ADDR_PWM0, n); wr(ADDR_PWM1, ~n); gap(2);
      chk(drive[0].pwm_cycles, exp_pwm(12'(n)));
      chk(drive[1].pwm_cycles, exp_pwm(12'(~n)));
    end
    // Quick shutoff across both sides and both transistors
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONFIG, i >> 1);
      code = (i == 3) ? SETPOINT_FULL : $urandom_range(1, 2046);
      wr(ADDR_SETPOINT0, 32'h8000 | code); gap(3);
      chk(drive[0].high_side, i >> 1);
      chk(drive[0].setpoint, code);
      chk(drive[0].stage_on, 1);
      want[0].oc_high_hs <= i[0]; want[0].oc_high_ls <= !i[0];
      gap(3); chk(drive[0].stage_on, 0);
      want[0] <= '0; gap(2); chk(drive[0].setpoint, 0);
      rd(ADDR_SETPOINT0); chk(d, 0);
      rd(ADDR_DIAG); chk(d[1:0], (i[1] == i[0]) ? 2'b01 : 2'b10);
      rd(ADDR_DIAG); chk(d[1:0], 2'b00);
    end
    wr(ADDR_SETPOINT0, 32'h8000); gap(3); chk(drive[0].stage_on, 0);
    wr(ADDR_SETPOINT0, 32'h8040); want[0].open_load_on <= 1'b1; gap(50);
    want[0] <= '0; rd(ADDR_DIAG); chk(d[1], 1);
    // Low limit: a short excursion is forgiven, a long one trips
    wr(ADDR_CONFIG, 0); wr(ADDR_SETPOINT0, 32'h8064);
    want[0].oc_low_ls <= 1'b1; gap(10); want[0] <= '0; gap(5);
    chk(drive[0].stage_on, 1);
    want[0].oc_low_ls <= 1'b1; n = 0; @(posedge aclk);
    while (drive[0].stage_on === 1'b1 && n < 100) begin @(posedge aclk); n++; end
    chk(n >= 20 && n <= 42, 1);
    want[0] <= '0; rd(ADDR_DIAG); chk(d[0], 1);
    // Overtemperature on channel 1 only
    wr(ADDR_SETPOINT0, 32'h8005); wr(ADDR_SETPOINT1, 32'h8009); gap(3);
    want[1].overtemp <= 1'b1; gap(5);
    chk({drive[1].stage_on, drive[1].setpoint}, 0);
    chk(drive[0].stage_on, 1);
    rd(ADDR_DIAG); chk(d[6], 1); rd(ADDR_DIAG); chk(d[6], 1);
    wr(ADDR_SETPOINT1, 32'h8009); gap(3); chk(drive[1].stage_on, 0);
    want[1].overtemp <= 1'b0; gap(5);
    wr(ADDR_SETPOINT1, 32'h8009); gap(3); chk(drive[1].stage_on, 0);
    rd(ADDR_DIAG); chk(d[6], 1); rd(ADDR_DIAG); chk(d[6], 0);
    wr(ADDR_SETPOINT1, 32'h8009); gap(3); chk(drive[1].stage_on, 1);
    // Supply surge, both monitor orders
    for (int i = 0; i < 2; i++) begin
      uv_first <= i; surge <= 1'b1; gap(6);
      chk({drive[0].stage_on, drive[1].stage_on}, 0);
      chk({drive[0].setpoint, drive[1].setpoint}, 0);
      rd(ADDR_DIAG); chk(d[9:8], 2'b11);
      surge <= 1'b0; gap(5);
      wr(ADDR_SETPOINT0, 32'h8005); gap(3); chk(drive[0].stage_on, 0);
      rd(ADDR_DIAG); chk(d[8], 1); rd(ADDR_DIAG); chk(d[8], 0);
      wr(ADDR_SETPOINT0, 32'h8005); wr(ADDR_SETPOINT1, 32'h8007); gap(3);
      chk({drive[0].stage_on, drive[1].stage_on}, 2'b11);
    end
    finish_test();
  end
endmodule
